/* pkg/wsio_map.vh */
// constants for the welder status and timesharing io block
`ifndef WSIO_MAP_VH
`define WSIO_MAP_VH
`define WSIO_CLK_HZ        10000000
`define WSIO_TICK_MS       1
`define WSIO_TICK_CYC      ((`WSIO_CLK_HZ / 1000) * `WSIO_TICK_MS)
`define WSIO_PULSE_MS      40
`define WSIO_OFF_CTRL      12'h000
`define WSIO_OFF_STAT      12'h004
`define WSIO_OFF_IRQ_ST    12'h008
`define WSIO_OFF_IRQ_MSK   12'h00C
`define WSIO_OFF_REFPWR    12'h010
`define WSIO_OFF_LAMPPWR   12'h014
`define WSIO_CTRL_INDEP    0
`define WSIO_CTRL_RST      8'h00
`define WSIO_EV_FAULT      0
`define WSIO_EV_FLASH      1
`define WSIO_EV_MONOK      2
`define WSIO_EV_MONBAD     3
`define WSIO_EV_OVERPWR    4
`define WSIO_EV_EXTSEL     5
`define WSIO_EV_W          6
`endif

/* logic/wsio_pulse.v */
// restartable fixed-length pulse timer counted in millisecond ticks
module wsio_pulse #(
	parameter LEN_MS = 40,
	parameter CW     = 8
) (
	sys_clk,
	rst,
	ce,
	tick,
	trig,
	pulse
);
	input  wire          sys_clk;
	input  wire          rst;
	input  wire          ce;
	input  wire          tick;
	input  wire          trig;
	output reg           pulse;
	reg    [CW-1:0]      cnt_r;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= {CW{1'b0}};
			pulse <= 1'b0;
		end else if (ce) begin
			if (trig) begin
				// restart from the top so back-to-back events stretch the pulse
				cnt_r <= LEN_MS[CW-1:0];
				pulse <= 1'b1;
			end else if (tick && cnt_r != {CW{1'b0}}) begin
				cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
				pulse <= (cnt_r != {{(CW-1){1'b0}}, 1'b1});
			end
		end
	end
endmodule // wsio_pulse

/* logic/wsio_top.v */
// welder status outputs, timesharing select inputs and apb register file
//
// Our own choices: the register addresses and register access over APB.
`include "wsio_map.vh"
module wsio_top #(
	parameter TICK_CYC = `WSIO_TICK_CYC,
	parameter PULSE_MS = `WSIO_PULSE_MS,
	parameter PWR_W    = 16
) (
	sys_clk,
	rst,
	ce,
	hv_on_in,
	cap_full_in,
	fault_in,
	flash_done_in,
	mon_valid_in,
	mon_in_range_in,
	lamp_power_in,
	fault_reset_pin,
	external_control_select_pin,
	ts_sel_pin,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	irq,
	ready_out,
	hv_on_out,
	trouble_closed_out,
	end_out,
	mon_ok_out,
	mon_bad_out,
	ext_recv_out,
	lamp_ok_out,
	unused_out,
	ts_unit_drive,
	ts_unit_on_out,
	ext_fault_reset
);
	input  wire              sys_clk;
	input  wire              rst;
	input  wire              ce;
	input  wire              hv_on_in;
	input  wire              cap_full_in;
	input  wire              fault_in;
	input  wire              flash_done_in;
	input  wire              mon_valid_in;
	input  wire              mon_in_range_in;
	input  wire [PWR_W-1:0]  lamp_power_in;
	input  wire              fault_reset_pin;
	input  wire              external_control_select_pin;
	input  wire [2:0]        ts_sel_pin;
	input  wire              psel;
	input  wire              penable;
	input  wire              pwrite;
	input  wire [11:0]       paddr;
	input  wire [31:0]       pwdata;
	output reg  [31:0]       prdata;
	output reg               pready;
	output reg               pslverr;
	output reg               irq;
	output reg               ready_out;
	output reg               hv_on_out;
	output reg               trouble_closed_out;
	output reg               end_out;
	output reg               mon_ok_out;
	output reg               mon_bad_out;
	output reg               ext_recv_out;
	output reg               lamp_ok_out;
	output reg  [5:0]        unused_out;
	output reg  [2:0]        ts_unit_drive;
	output reg  [2:0]        ts_unit_on_out;
	output reg               ext_fault_reset;

	localparam TCW = 16;
	localparam [31:0] TICK_SPAN = TICK_CYC - 1;
	localparam [TCW-1:0] TICK_LAST = TICK_SPAN[TCW-1:0];

	// three-stage sync; only stages two and three are looked at
	reg  [4:0]           s1_r;
	reg  [4:0]           s2_r;
	reg  [4:0]           s3_r;
	reg  [4:0]           pin_r;
	wire [4:0]           raw_pins;
	assign raw_pins = {ts_sel_pin, fault_reset_pin, external_control_select_pin};

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_r  <= 5'h00;
			s2_r  <= 5'h00;
			s3_r  <= 5'h00;
			pin_r <= 5'h00;
		end else if (ce) begin
			s1_r  <= raw_pins;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
		end
	end

	wire       sel_q   = pin_r[0];
	wire       frst_q  = pin_r[1];
	wire [2:0] ts_q    = pin_r[4:2];

	// millisecond tick
	// ce low freezes the divider too, so a status pulse stretches by the frozen time
	reg  [TCW-1:0]  tdiv_r;
	reg             tick_r;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tdiv_r <= {TCW{1'b0}};
			tick_r <= 1'b0;
		end else if (ce) begin
			tick_r <= (tdiv_r == TICK_LAST);
			tdiv_r <= (tdiv_r == TICK_LAST) ? {TCW{1'b0}} : tdiv_r + 16'h0001;
		end
	end

	// event edges
	reg  flash_d_r;
	reg  mon_d_r;
	reg  fault_d_r;
	wire flash_ev  = flash_done_in & ~flash_d_r;
	wire mon_ev    = mon_valid_in & ~mon_d_r;
	wire mon_ok_ev = mon_ev & mon_in_range_in;
	wire mon_bd_ev = mon_ev & ~mon_in_range_in;
	wire fault_ev  = fault_in & ~fault_d_r;

	// registers
	reg  [7:0]        ctrl_r;
	reg  [PWR_W-1:0]  ref_pwr_r;
	reg  [`WSIO_EV_W-1:0] ist_r;
	reg  [`WSIO_EV_W-1:0] imsk_r;
	reg               alarm_r;
	reg               sel_d_r;
	reg               over_d_r;
	wire              over_pwr = (lamp_power_in > ref_pwr_r);
	wire              indep    = ctrl_r[`WSIO_CTRL_INDEP];
	wire              acc      = psel & penable;
	wire              wr       = acc & pwrite;
	wire              wr_done  = wr & pready;
	wire              map_hit  = (paddr == `WSIO_OFF_CTRL) || (paddr == `WSIO_OFF_STAT) ||
	                             (paddr == `WSIO_OFF_IRQ_ST) || (paddr == `WSIO_OFF_IRQ_MSK) ||
	                             (paddr == `WSIO_OFF_REFPWR) || (paddr == `WSIO_OFF_LAMPPWR);
	wire [`WSIO_EV_W-1:0] ev_vec = {sel_q & ~sel_d_r, over_pwr & ~over_d_r, mon_bd_ev,
	                                mon_ok_ev, flash_ev, fault_ev};
	wire [`WSIO_EV_W-1:0] clr_vec = (wr && paddr == `WSIO_OFF_IRQ_ST) ?
	                                pwdata[`WSIO_EV_W-1:0] : {`WSIO_EV_W{1'b0}};
	wire [`WSIO_EV_W-1:0] ist_nxt = (ist_r & ~clr_vec) | ev_vec;
	wire [`WSIO_EV_W-1:0] ist_upd = wr_done ? ist_nxt : (ist_r | ev_vec);
	// status ready and hv bits read the live inputs, a cycle ahead of the registered pins
	wire [31:0] stat_word = {20'h00000, ts_unit_on_out, alarm_r, over_pwr, sel_q,
	                         mon_bad_out, mon_ok_out, end_out, alarm_r, hv_on_in,
	                         hv_on_in & cap_full_in};

	reg  [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		case (paddr)
		`WSIO_OFF_CTRL:    rd_mux = {24'h000000, ctrl_r};
		`WSIO_OFF_STAT:    rd_mux = stat_word;
		`WSIO_OFF_IRQ_ST:  rd_mux = {{(32-`WSIO_EV_W){1'b0}}, ist_r};
		`WSIO_OFF_IRQ_MSK: rd_mux = {{(32-`WSIO_EV_W){1'b0}}, imsk_r};
		`WSIO_OFF_REFPWR:  rd_mux = {{(32-PWR_W){1'b0}}, ref_pwr_r};
		`WSIO_OFF_LAMPPWR: rd_mux = {{(32-PWR_W){1'b0}}, lamp_power_in};
		default:           rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r    <= `WSIO_CTRL_RST;
			ref_pwr_r <= {PWR_W{1'b1}};
			ist_r     <= {`WSIO_EV_W{1'b0}};
			imsk_r    <= {`WSIO_EV_W{1'b0}};
			prdata    <= 32'h00000000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			irq       <= 1'b0;
			flash_d_r <= 1'b0;
			mon_d_r   <= 1'b0;
			fault_d_r <= 1'b0;
			sel_d_r   <= 1'b0;
			over_d_r  <= 1'b0;
		end else if (ce) begin
			flash_d_r <= flash_done_in;
			mon_d_r   <= mon_valid_in;
			fault_d_r <= fault_in;
			sel_d_r   <= sel_q;
			over_d_r  <= over_pwr;
			// one wait state: pready is set at the end of the first access cycle, stands in the second, drops after
			pready    <= psel & penable & ~pready;
			pslverr   <= psel & penable & ~pready & ~map_hit;
			// read data is taken in the wait cycle so it stands at the pready edge
			prdata    <= (psel & ~pwrite & map_hit) ? rd_mux : 32'h00000000;
			if (wr && pready && paddr == `WSIO_OFF_CTRL)
				ctrl_r <= pwdata[7:0];
			if (wr && pready && paddr == `WSIO_OFF_IRQ_MSK)
				imsk_r <= pwdata[`WSIO_EV_W-1:0];
			if (wr && pready && paddr == `WSIO_OFF_REFPWR)
				ref_pwr_r <= pwdata[PWR_W-1:0];
			// a new event wins over a write-one clear in the same cycle
			ist_r <= ist_upd;
			irq   <= |(ist_upd & imsk_r);
		end
	end

	// fault latch; reset only acts once the cause is gone and the pin is honoured
	wire accepted_reset = frst_q & sel_q;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			alarm_r <= 1'b0;
		end else if (ce) begin
			if (fault_in)
				alarm_r <= 1'b1;
			else if (accepted_reset)
				alarm_r <= 1'b0;
		end
	end

	wire end_p;
	wire ok_p;
	wire bad_p;
	wsio_pulse #(.LEN_MS(PULSE_MS), .CW(8)) u_end (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.tick    (tick_r),
		.trig    (flash_ev),
		.pulse   (end_p)
	);
	wsio_pulse #(.LEN_MS(PULSE_MS), .CW(8)) u_ok (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.tick    (tick_r),
		.trig    (mon_ok_ev),
		.pulse   (ok_p)
	);
	wsio_pulse #(.LEN_MS(PULSE_MS), .CW(8)) u_bad (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.tick    (tick_r),
		.trig    (mon_bd_ev),
		.pulse   (bad_p)
	);

	// no interlock between units: several may be driven at once
	// timesharing select only honoured in independent mode with inputs accepted
	wire [2:0] ts_req = (indep && sel_q) ? ts_q : 3'h0;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ready_out          <= 1'b0;
			hv_on_out          <= 1'b0;
			trouble_closed_out <= 1'b0;
			end_out            <= 1'b0;
			mon_ok_out         <= 1'b0;
			mon_bad_out        <= 1'b0;
			ext_recv_out       <= 1'b0;
			lamp_ok_out        <= 1'b0;
			unused_out         <= 6'h00;
			ts_unit_drive      <= 3'h0;
			ts_unit_on_out     <= 3'h0;
			ext_fault_reset    <= 1'b0;
		end else if (ce) begin
			ready_out          <= hv_on_in & cap_full_in;
			hv_on_out          <= hv_on_in;
			trouble_closed_out <= ~(alarm_r | fault_in);
			end_out            <= end_p;
			mon_ok_out         <= ok_p;
			mon_bad_out        <= bad_p;
			ext_recv_out       <= sel_q;
			lamp_ok_out        <= ~over_pwr;
			unused_out         <= 6'h00;
			ts_unit_drive      <= ts_req;
			ts_unit_on_out     <= ts_unit_drive;
			ext_fault_reset    <= accepted_reset;
		end
	end
endmodule // wsio_top

/* bench/wsio_top_checker.sv */
// concurrent checks on the welder status io top ports
module wsio_chk #(
	parameter TICK_CYC = 10000,
	parameter PULSE_MS = 40
) (
	input wire       sys_clk,
	input wire       rst,
	input wire       ce,
	input wire       hv_on_in,
	input wire       cap_full_in,
	input wire       fault_in,
	input wire       flash_done_in,
	input wire       mon_valid_in,
	input wire       mon_in_range_in,
	input wire       ready_out,
	input wire       hv_on_out,
	input wire       trouble_closed_out,
	input wire       end_out,
	input wire       mon_ok_out,
	input wire       mon_bad_out,
	input wire       ext_recv_out,
	input wire [5:0] unused_out,
	input wire [2:0] ts_unit_drive,
	input wire [2:0] ts_unit_on_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst || !ce);
	int len_r;
	// restart on each flash so a retriggered pulse is measured from its own event
	always @(posedge sys_clk or posedge rst)
		if (rst)
			len_r <= 0;
		else if (ce)
			len_r <= (end_out && !$rose(flash_done_in)) ? len_r + 1 : 0;
	sequence s_flash; $rose(flash_done_in); endsequence
	sequence s_meas_ok; $rose(mon_valid_in) && mon_in_range_in; endsequence
	sequence s_meas_bad; $rose(mon_valid_in) && !mon_in_range_in; endsequence
	a_ready_needs_hv: assert property (ready_out |-> $past(hv_on_in && cap_full_in))
		else $error("ready without hv and charge");
	a_hv_follows: assert property (hv_on_out == $past(hv_on_in))
		else $error("hv status mismatch");
	a_trouble_opens: assert property (fault_in |-> ##[1:4] !trouble_closed_out)
		else $error("trouble stayed closed");
	a_flash_end: assert property (s_flash |-> ##[1:4] end_out)
		else $error("no end pulse");
	a_end_length: assert property ($fell(end_out) |-> len_r >= (PULSE_MS - 1) * TICK_CYC
		&& len_r <= (PULSE_MS + 1) * TICK_CYC + 4)
		else $error("end pulse length");
	a_mon_ok: assert property (s_meas_ok |-> ##[1:4] mon_ok_out)
		else $error("no monitor normal pulse");
	a_mon_bad: assert property (s_meas_bad |-> ##[1:4] mon_bad_out)
		else $error("no monitor trouble pulse");
	a_ts_gated: assert property (ts_unit_drive != 3'h0 |-> ext_recv_out
		|| $past(ext_recv_out) || $past(ext_recv_out, 2))
		else $error("timesharing driven while not receivable");
	a_unit_on: assert property (ts_unit_on_out == $past(ts_unit_drive))
		else $error("unit on status mismatch");
	a_unused_open: assert property (unused_out == 6'h00)
		else $error("unused output closed");
endmodule // wsio_chk

/* bench/wsio_ctrl_model.sv */
// automation controller model driving the contact-closure inputs
module wsio_ctrl_model (
	input  logic       sys_clk,
	input  logic       want_sel,
	input  logic       want_rst,
	input  logic [2:0] want_ts,
	output logic       sel_pin,
	output logic       rst_pin,
	output logic [2:0] ts_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {sel_pin, rst_pin, ts_pin} = 5'h00;
	// contacts only move just after an edge, like a relay card on the same clock
	always @(posedge sys_clk) begin
		sel_pin <= want_sel;
		rst_pin <= want_rst;
		ts_pin  <= want_ts;
	end
endmodule // wsio_ctrl_model

/* bench/wsio_top_tb_top.sv */
// self-checking bench for the welder status io top
`include "wsio_map.vh"
module wsio_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam TICK_CYC = 10;
	localparam PULSE_MS = 8;
	logic sys_clk = 0, rst = 1, ce = 1, hv_on_in = 0, cap_full_in = 0, fault_in = 0;
	logic flash_done_in = 0, mon_valid_in = 0, mon_in_range_in = 0, want_sel = 0, want_rst = 0;
	logic psel = 0, penable = 0, pwrite = 0, se;
	logic [2:0] want_ts = 0, ts_sel_pin, ts_unit_drive, ts_unit_on_out;
	logic [15:0] lamp_power_in = 16'h0000;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, ready_out, hv_on_out, trouble_closed_out, end_out, mon_ok_out;
	logic mon_bad_out, ext_recv_out, lamp_ok_out, ext_fault_reset, fault_reset_pin;
	logic external_control_select_pin;
	logic [5:0] unused_out;
	int err_total = 0, n_tests = 0;
	always #50 sys_clk = ~sys_clk;
	wsio_top #(.TICK_CYC(TICK_CYC), .PULSE_MS(PULSE_MS)) uut (
		.sys_clk(sys_clk), .rst(rst), .ce(ce), .hv_on_in(hv_on_in),
		.cap_full_in(cap_full_in), .fault_in(fault_in),
		.flash_done_in(flash_done_in), .mon_valid_in(mon_valid_in),
		.mon_in_range_in(mon_in_range_in), .lamp_power_in(lamp_power_in),
		.fault_reset_pin(fault_reset_pin),
		.external_control_select_pin(external_control_select_pin),
		.ts_sel_pin(ts_sel_pin), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .ready_out(ready_out),
		.hv_on_out(hv_on_out), .trouble_closed_out(trouble_closed_out),
		.end_out(end_out), .mon_ok_out(mon_ok_out), .mon_bad_out(mon_bad_out),
		.ext_recv_out(ext_recv_out), .lamp_ok_out(lamp_ok_out),
		.unused_out(unused_out), .ts_unit_drive(ts_unit_drive),
		.ts_unit_on_out(ts_unit_on_out), .ext_fault_reset(ext_fault_reset));
	wsio_ctrl_model u_ctl (.sys_clk, .want_sel, .want_rst, .want_ts,
		.sel_pin(external_control_select_pin), .rst_pin(fault_reset_pin), .ts_pin(ts_sel_pin));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// the wait state count is not assumed; only the bound cuts a missing answer short
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20)
			chk("pready", 1, 0);
	endtask
	task automatic summarize();
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#500000;
		err_total++;
		summarize();
	end
	initial begin
		cyc(16);
		rst <= 1'b0;
		apb(0, `WSIO_OFF_CTRL, 0);
		chk("ctrl", 0, rd);
		apb(0, `WSIO_OFF_REFPWR, 0);
		chk("refpwr", 32'h0000FFFF, rd);
		apb(0, 12'h020, 0);
		chk("slverr", 1, se);
		chk("unmapped", 0, rd);
		chk("trouble", 1, trouble_closed_out);
		hv_on_in <= 1'b1;
		cyc(3);
		chk("ready", 0, ready_out);
		chk("hv", 1, hv_on_out);
		cap_full_in <= 1'b1;
		cyc(3);
		apb(0, `WSIO_OFF_STAT, 0);
		chk("ready", 1, ready_out);
		chk("stat", 3, rd[1:0]);
		hv_on_in <= 1'b0;
		cyc(3);
		chk("ready", 0, ready_out);
		chk("hv", 0, hv_on_out);
		flash_done_in <= 1'b1;
		cyc(4);
		chk("end", 1, end_out);
		flash_done_in <= 1'b0;
		cyc(56);
		flash_done_in <= 1'b1;
		cyc(40);
		chk("end_restart", 1, end_out);
		cyc(60);
		chk("end_off", 0, end_out);
		chk("irq_idle", 0, irq);
		apb(0, `WSIO_OFF_IRQ_ST, 0);
		chk("irq_flash", 32'h00000002, rd);
		apb(1, `WSIO_OFF_IRQ_MSK, 32'h3F);
		cyc(2);
		chk("irq_mask", 1, irq);
		apb(1, `WSIO_OFF_IRQ_ST, 32'h3F);
		cyc(2);
		chk("irq_clr", 0, irq);
		apb(0, `WSIO_OFF_IRQ_ST, 0);
		chk("irq_st", 0, rd);
		for (int r = 0; r < 2; r++) begin
			mon_in_range_in <= r[0];
			cyc(1);
			mon_valid_in <= 1'b1;
			cyc(4);
			chk("mon_ok", r, mon_ok_out);
			chk("mon_bad", !r, mon_bad_out);
			mon_valid_in <= 1'b0;
			cyc(PULSE_MS * TICK_CYC + 20);
		end
		apb(1, `WSIO_OFF_REFPWR, 32'h0100);
		lamp_power_in <= 16'h0101;
		cyc(3);
		chk("lamp_ok", 0, lamp_ok_out);
		lamp_power_in <= 16'h0100;
		cyc(3);
		chk("lamp_ok", 1, lamp_ok_out);
		want_ts <= 3'h5;
		want_sel <= 1'b1;
		cyc(8);
		chk("recv", 1, ext_recv_out);
		chk("ts_off", 0, ts_unit_drive);
		apb(1, `WSIO_OFF_CTRL, 32'h1);
		cyc(3);
		chk("ts_drv", 5, ts_unit_drive);
		chk("ts_on", 5, ts_unit_on_out);
		apb(0, `WSIO_OFF_STAT, 0);
		chk("stat_ts", 32'h00000A40, rd);
		want_sel <= 1'b0;
		cyc(8);
		chk("recv", 0, ext_recv_out);
		chk("ts_gate", 0, ts_unit_drive);
		fault_in <= 1'b1;
		cyc(3);
		fault_in <= 1'b0;
		want_rst <= 1'b1;
		cyc(8);
		chk("trouble", 0, trouble_closed_out);
		chk("fault_rst_out", 0, ext_fault_reset);
		want_sel <= 1'b1;
		cyc(8);
		chk("trouble", 1, trouble_closed_out);
		chk("fault_rst_out", 1, ext_fault_reset);
		ce <= 1'b0;
		cyc(2);
		hv_on_in <= 1'b1;
		cyc(3);
		chk("ce_freeze", 0, hv_on_out);
		hv_on_in <= 1'b0;
		cyc(1);
		ce <= 1'b1;
		cyc(3);
		chk("ce_resume", 0, hv_on_out);
		summarize();
	end
endmodule // wsio_top_tb_top
bind wsio_top wsio_chk #(.TICK_CYC(TICK_CYC), .PULSE_MS(PULSE_MS)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .ce(ce), .hv_on_in(hv_on_in),
	.cap_full_in(cap_full_in), .fault_in(fault_in), .flash_done_in(flash_done_in),
	.mon_valid_in(mon_valid_in), .mon_in_range_in(mon_in_range_in),
	.ready_out(ready_out), .hv_on_out(hv_on_out),
	.trouble_closed_out(trouble_closed_out), .end_out(end_out),
	.mon_ok_out(mon_ok_out), .mon_bad_out(mon_bad_out),
	.ext_recv_out(ext_recv_out), .unused_out(unused_out),
	.ts_unit_drive(ts_unit_drive), .ts_unit_on_out(ts_unit_on_out));
